/* File: burst_fifo.sv */
`timescale 1ns/1ps
module burst_fifo #(
  parameter int W = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic inValid, // Push request
  output logic inReady, // Room for one word
  input wire logic [W-1:0] inData, // Word to push
  output logic outValid, // Word available
  input wire logic outReady, // Pop request
  output logic [W-1:0] outData // Head word
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = DEPTH[PW:0];
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

  logic [W-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr_ff;
  logic [PW-1:0] rdPtr_ff;
  logic [PW:0] count_ff;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  // Honest full and empty from the count
  assign inReady = (count_ff != DEPTH_C);
  assign outValid = (count_ff != '0);
  assign outData = store[rdPtr_ff];

  // Pointers and occupancy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wrPtr_ff <= (wrPtr_ff == LAST_C) ? '0 : wrPtr_ff + 1'b1;
      if (pop) rdPtr_ff <= (rdPtr_ff == LAST_C) ? '0 : rdPtr_ff + 1'b1;
      count_ff <= count_ff + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) store[wrPtr_ff] <= inData;
  end
endmodule // burst_fifo

/* File: burst_sram_ports.sv */
// What this block does
// - Each access moves four 18-bit words, two cycles
// - Bypass high: read latency two and half cycles
// - Bypass low: legacy one-cycle read latency
// - Accesses start only on K rising edges
// - Write data registered on both K edges
// - Read data launched from registers, both edges
// - Selects and byte selects sampled in registers
// - Storage is four 1M by 18 banks
// - Read select latches address into read register
// - First word after third following K-bar rise, bypass high
// - Remaining words follow on each next edge
// - Read right after read is ignored
// - Deselect: finish burst, tristate after K-bar rise
// - Write select starts burst at presented address
// - First write word on next K rise
// - Second word on K-bar, four words total
// - Four words committed in one internal write
// - Write right after write is ignored
// - Deselected write port ignores write inputs
// - Inactive byte select leaves memory byte unchanged
// - Address bus 20 bits, one burst location
// - Burst words map to four sequential positions
// - Both selects from idle: read first, alternate
`timescale 1ns/1ps
module burst_sram_ports import qburst_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int FDEPTH = FIFO_DEPTH
) (
  input wire logic clk, // 20 MHz, one edge per K or K-bar rise
  input wire logic resetn, // Async reset, active low
  input wire logic [AW-1:0] address, // Shared burst address
  input wire logic readPortSelectN, // Read port select, low active
  input wire logic writePortSelectN, // Write port select, low active
  input wire logic [LANES-1:0] byteLaneWriteSelectN, // Byte write selects, low active
  input wire logic [WORD_W-1:0] writeData, // Write data word
  input wire logic pllBypassN, // Low selects legacy latency
  output logic [WORD_W-1:0] readData, // Read data word
  output logic readDataOe, // High while read data driven
  output logic negPhase // High: coming edge is a K-bar rise
);
  localparam int DEPTH = 1 << AW;

  // ****************************************
  // Half-cycle phase and strap sync
  // ****************************************
  logic phase_ff;
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic latMode_ff;

  // Phase toggles each edge; even edges are K rises
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) phase_ff <= PHASE_K_RISE;
    else phase_ff <= ~phase_ff;
  end
  assign negPhase = phase_ff;
  wire kRise = (phase_ff == PHASE_K_RISE);

  // Bypass pin through three flops, taken when two agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= LAT_MODE_RST;
      sync2_ff <= LAT_MODE_RST;
      sync3_ff <= LAT_MODE_RST;
      latMode_ff <= LAT_MODE_RST;
    end else begin
      sync1_ff <= pllBypassN;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) latMode_ff <= sync3_ff;
    end
  end

  // ****************************************
  // Arbitration of access starts
  // ****************************************
  logic prevRead_ff;
  logic prevWrite_ff;
  logic [BURST_CNT_W-1:0] rdLeft_ff;
  logic [AW-1:0] rdAddr_ff;
  wire fifoInReady;
  wire pushWord = (rdLeft_ff != CNT_ZERO) & fifoInReady;
  wire rdRoom = (rdLeft_ff == CNT_ZERO) | ((rdLeft_ff == CNT_ONE) & pushWord);
  wire rdSel = ~readPortSelectN & kRise;
  wire wrSel = ~writePortSelectN & kRise;
  // Read after read dropped; read wins unless it just ran
  wire rdAccept = rdSel & ~prevRead_ff & rdRoom;
  wire wrAccept = wrSel & ~prevWrite_ff & ~rdAccept;

  // Previous K rise history, held across K-bar edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prevRead_ff <= 1'b0;
      prevWrite_ff <= 1'b0;
    end else if (kRise) begin
      prevRead_ff <= rdAccept;
      prevWrite_ff <= wrAccept;
    end
  end

  // ****************************************
  // Write collection and commit
  // ****************************************
  logic [WR_SR_W-1:0] wrSr_ff;
  logic [AW-1:0] wrAddrNew_ff;
  logic [AW-1:0] wrAddrCur_ff;
  logic [WORD_W-1:0] wrBuf_ff [BURST_LEN];
  logic [LANES-1:0] wrMask_ff [BURST_LEN];
  wire commit = wrSr_ff[WR_COMMIT_TAP];

  // Start token walks through the word slots
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) wrSr_ff <= '0;
    else wrSr_ff <= {wrSr_ff[WR_SR_W-2:0], wrAccept};
  end

  // Address of a new write, then of the burst being collected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrAddrNew_ff <= '0;
      wrAddrCur_ff <= '0;
    end else begin
      if (wrAccept) wrAddrNew_ff <= address;
      if (wrSr_ff[WR_WORD0_TAP]) wrAddrCur_ff <= wrAddrNew_ff;
    end
  end

  // ****************************************
  // Banks, one per burst word position
  // ****************************************
  logic [WORD_W-1:0] bankRd [BURST_LEN];
  wire [1:0] rdWord = 2'(BURST_LEN_C - rdLeft_ff);

  genvar k;
  generate
    for (k = 0; k < BURST_LEN; k++) begin : g_word
      logic [WORD_W-1:0] bank [DEPTH];
      // Last word comes live with the commit edge
      wire [WORD_W-1:0] cWord = (k == BURST_LEN - 1) ? writeData : wrBuf_ff[k];
      wire [LANES-1:0] cMask = (k == BURST_LEN - 1) ? ~byteLaneWriteSelectN : wrMask_ff[k];
      wire [AW-1:0] cAddr = (k == 0) ? wrAddrNew_ff : wrAddrCur_ff;
      wire slot = wrSr_ff[WR_WORD0_TAP + k];
      assign bankRd[k] = bank[rdAddr_ff];

      // Capture word and byte selects on its edge only
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          wrBuf_ff[k] <= WORD_RST;
          wrMask_ff[k] <= '0;
        end else if (slot) begin
          wrBuf_ff[k] <= writeData;
          wrMask_ff[k] <= ~byteLaneWriteSelectN;
        end
      end

      // Single commit; unselected bytes keep their contents
      for (genvar b = 0; b < LANES; b++) begin : g_lane
        always_ff @(posedge clk) begin
          if (commit && cMask[b]) begin
            bank[wrAddrCur_ff][b*BYTE_W +: BYTE_W] <= cWord[b*BYTE_W +: BYTE_W];
          end
        end
      end
      wire unusedAddr = ^cAddr;
    end
  endgenerate

  // ****************************************
  // Read fetch into the output FIFO
  // ****************************************
  wire [WORD_W-1:0] fifoOutData;
  wire fifoOutValid;
  logic [BURST_CNT_W-1:0] outCnt_ff;
  logic [RD_LAT_PLL_HALF-1:0] startSr_ff;
  wire tap = latMode_ff ? startSr_ff[RD_LAT_PLL_HALF-1] : startSr_ff[RD_LAT_LEGACY_HALF-1];
  wire emit = (outCnt_ff != CNT_ZERO) | tap;
  wire popWord = emit & fifoOutValid;

  // Burst counter and latched read address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdLeft_ff <= CNT_ZERO;
      rdAddr_ff <= '0;
    end else begin
      if (rdAccept) rdAddr_ff <= address;
      rdLeft_ff <= rdAccept ? BURST_LEN_C : rdLeft_ff - {2'h0, pushWord};
    end
  end

  burst_fifo #(.W(WORD_W), .DEPTH(FDEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .inValid(rdLeft_ff != CNT_ZERO),
    .inReady(fifoInReady),
    .inData(bankRd[rdWord]),
    .outValid(fifoOutValid),
    .outReady(popWord),
    .outData(fifoOutData)
  );

  // ****************************************
  // Output launch and tristate
  // ****************************************
  // Latency line and count of words still owed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startSr_ff <= '0;
      outCnt_ff <= CNT_ZERO;
    end else begin
      startSr_ff <= {startSr_ff[RD_LAT_PLL_HALF-2:0], rdAccept};
      outCnt_ff <= outCnt_ff + (tap ? BURST_LEN_C : CNT_ZERO) - {2'h0, popWord};
    end
  end

  // Output register; enable drops only on a K-bar edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readData <= WORD_RST;
      readDataOe <= 1'b0;
    end else begin
      if (popWord) readData <= fifoOutData;
      readDataOe <= popWord | (readDataOe & ~phase_ff);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_pll_latency: assert property (@(posedge clk) disable iff (!resetn)
    (rdAccept && latMode_ff && $stable(latMode_ff)) |-> ##6 readDataOe ##0 $past(popWord))
    else $error("read burst late with pll on");
  a_legacy_latency: assert property (@(posedge clk) disable iff (!resetn)
    (rdAccept && !latMode_ff) ##1 !latMode_ff |-> ##1 popWord)
    else $error("read burst late in legacy mode");
  a_burst_four: assert property (@(posedge clk) disable iff (!resetn)
    $rose(readDataOe) |-> readDataOe [*4])
    else $error("read burst shorter than four words");
  a_read_ignored: assert property (@(posedge clk) disable iff (!resetn)
    rdAccept |-> ##2 !rdAccept)
    else $error("read started on consecutive K rises");
  a_write_ignored: assert property (@(posedge clk) disable iff (!resetn)
    wrAccept |-> ##2 !wrAccept)
    else $error("write started on consecutive K rises");
  a_start_on_k: assert property (@(posedge clk) disable iff (!resetn)
    (rdAccept || wrAccept) |-> !phase_ff)
    else $error("access started on a K-bar edge");
  a_tristate_kbar: assert property (@(posedge clk) disable iff (!resetn)
    $fell(readDataOe) |-> $past(phase_ff) && !$past(popWord))
    else $error("output released off a K-bar edge");
  a_commit_timing: assert property (@(posedge clk) disable iff (!resetn)
    wrAccept |-> ##5 commit)
    else $error("write commit not five edges after start");
  a_read_priority: assert property (@(posedge clk) disable iff (!resetn)
    (rdSel && wrSel && !prevRead_ff && !prevWrite_ff && rdRoom) |-> rdAccept && !wrAccept)
    else $error("read did not win from idle");
endmodule // burst_sram_ports

/* File: mem_ctrl_model.sv */
`timescale 1ns/1ps
module mem_ctrl_model import qburst_pkg::*; #(
  parameter int AW = 6
) (
  input wire logic clk, // System clock
  input wire logic negPhase, // High: next edge is a K-bar rise
  output logic [AW-1:0] address, // Burst address
  output logic readPortSelectN, // Read select, low active
  output logic writePortSelectN, // Write select, low active
  output logic [LANES-1:0] byteLaneWriteSelectN, // Byte selects, low active
  output logic [WORD_W-1:0] writeData // Write word
);
  // ****************************************
  // Controller side of the burst ports
  // ****************************************
  initial begin
    address = '0;
    readPortSelectN = 1'b1;
    writePortSelectN = 1'b1;
    byteLaneWriteSelectN = 2'h3;
    writeData = '0;
  end

  // Let n edges pass, then wait 5 ns past the last one
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // Wait until the coming edge is a K rise
  task automatic align();
    idle(1);
    if (negPhase) idle(1);
  endtask

  // Selects and address for one K rise, then released
  task automatic request(input logic rd, input logic wr, input logic [AW-1:0] a);
    readPortSelectN = !rd;
    writePortSelectN = !wr;
    address = a;
    idle(1);
    readPortSelectN = 1'b1;
    writePortSelectN = 1'b1;
    address = ~a;
  endtask

  // Four words from the second K rise on; again repeats the start
  task automatic wdata(input logic [4*WORD_W-1:0] d, input logic [7:0] m, input logic again);
    idle(1);
    for (int j = 0; j < 4; j++) begin
      writeData = d[j*WORD_W +: WORD_W];
      byteLaneWriteSelectN = m[2*j +: 2];
      writePortSelectN = !(again && j == 0);
      idle(1);
    end
    writePortSelectN = 1'b1;
    writeData = ~writeData;
    byteLaneWriteSelectN = 2'h3;
  endtask
endmodule // mem_ctrl_model

/* File: qburst_pkg.sv */
package qburst_pkg;
  // ****************************************
  // Data and address geometry
  // ****************************************
  localparam int WORD_W = 18;
  localparam int BYTE_W = 9;
  localparam int LANES = 2;
  localparam int ADDR_W = 20;
  localparam int BURST_LEN = 4;
  localparam int BURST_CNT_W = 3;
  localparam logic [BURST_CNT_W-1:0] BURST_LEN_C = 3'h4;
  localparam logic [BURST_CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [BURST_CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam int FIFO_DEPTH = 8;

  // ****************************************
  // Timing, in half cycles of the K pair; clock period in ns
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int RD_LAT_PLL_HALF = 5;
  localparam int RD_LAT_LEGACY_HALF = 2;
  localparam int WR_WORD0_TAP = 1;
  localparam int WR_COMMIT_TAP = 4;
  localparam int WR_SR_W = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic PHASE_K_RISE = 1'b0;
  localparam logic LAT_MODE_RST = 1'b1;
  localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;
endpackage

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top import qburst_pkg::*;;
  localparam int AWS = 6;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pllBypassN = 1'b1;
  logic [AWS-1:0] address;
  logic readPortSelectN, writePortSelectN, negPhase, readDataOe;
  logic [LANES-1:0] byteLaneWriteSelectN;
  logic [WORD_W-1:0] writeData, readData;
  logic [WORD_W-1:0] mem [0:255];
  logic [AWS-1:0] addrs [0:7];
  int error_cnt = 0, tests_run = 0, seed = 32'h71b2;

  // ****************************************
  // Clock, design and controller
  // ****************************************
  initial begin
    forever #25 clk = ~clk;
  end

  burst_sram_ports #(.AW(AWS), .FDEPTH(FIFO_DEPTH)) dut (.clk(clk), .resetn(resetn), .address(address),
    .readPortSelectN(readPortSelectN), .writePortSelectN(writePortSelectN), .writeData(writeData),
    .byteLaneWriteSelectN(byteLaneWriteSelectN), .pllBypassN(pllBypassN), .readData(readData),
    .readDataOe(readDataOe), .negPhase(negPhase));
  mem_ctrl_model #(.AW(AWS)) ctrl (.clk(clk), .negPhase(negPhase), .address(address),
    .readPortSelectN(readPortSelectN), .writePortSelectN(writePortSelectN),
    .byteLaneWriteSelectN(byteLaneWriteSelectN), .writeData(writeData));

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic cmp(input logic [WORD_W:0] got, input logic [WORD_W:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks run %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Byte lanes with low select take the new data
  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old, input logic [WORD_W-1:0] d,
      input logic [LANES-1:0] m);
    merge = old;
    if (!m[0]) merge[8:0] = d[8:0];
    if (!m[1]) merge[17:9] = d[17:9];
  endfunction

  // Four words from edge lat on, then outputs released
  task automatic chk(input logic [AWS-1:0] a, input int lat, input logic last);
    repeat (lat + 1) @(posedge clk);
    for (int j = 0; j < 4; j++) begin
      #1 cmp({readDataOe, readData}, {1'b1, mem[{a, 2'(j)}]});
      @(posedge clk);
    end
    if (last) begin
      if (lat != 5) @(posedge clk);
      #1 cmp({18'h0, readDataOe}, 19'h0);
    end
  endtask

  task automatic rd(input logic [AWS-1:0] a, input int lat, input logic last);
    fork
      chk(a, lat, last);
    join_none
    ctrl.request(1'b1, 1'b0, a);
  endtask

  task automatic wr(input logic [AWS-1:0] a, input logic [4*WORD_W-1:0] d, input logic [7:0] m,
      input logic again, input logic both);
    ctrl.request(both, 1'b1, a);
    ctrl.wdata(d, m, again);
    for (int j = 0; j < 4; j++) mem[{a, 2'(j)}] = merge(mem[{a, 2'(j)}], d[j*WORD_W +: WORD_W], m[2*j +: 2]);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [4*WORD_W-1:0] d;
    repeat (10) @(posedge clk);
    #5 cmp({18'h0, readDataOe}, 19'h0);
    resetn = 1'b1;
    // Random full writes read back, corner addresses first
    for (int i = 0; i < 8; i++) begin
      addrs[i] = (i == 0) ? '0 : (i == 1) ? '1 : AWS'($random(seed));
      d = 72'({$random(seed), $random(seed), $random(seed)});
      ctrl.align();
      wr(addrs[i], d, 8'h00, 1'b0, 1'b0);
      rd(addrs[i], 5, 1'b1);
      ctrl.idle(10);
    end
    // Masked overwrite, then a write start right after a write
    d = 72'({$random(seed), $random(seed), $random(seed)});
    ctrl.align();
    wr(addrs[0], d, 8'($random(seed)), 1'b0, 1'b0);
    wr(addrs[1], ~d, 8'h00, 1'b1, 1'b0);
    ctrl.idle(4);
    // Reads on every other K rise give one unbroken stream
    ctrl.align();
    for (int i = 0; i < 8; i++) begin
      rd(addrs[i], 5, i == 7);
      ctrl.idle(3);
    end
    ctrl.idle(10);
    // Read on the next K rise after a read is dropped
    ctrl.align();
    rd(addrs[2], 5, 1'b1);
    ctrl.idle(1);
    ctrl.request(1'b1, 1'b0, addrs[3]);
    ctrl.idle(12);
    // Both selects from idle: read first, then write
    d = 72'({$random(seed), $random(seed), $random(seed)});
    ctrl.align();
    fork
      chk(addrs[4], 5, 1'b1);
    join_none
    ctrl.request(1'b1, 1'b1, addrs[4]);
    ctrl.idle(1);
    wr(addrs[5], d, 8'h00, 1'b0, 1'b1);
    ctrl.idle(10);
    ctrl.align();
    rd(addrs[5], 5, 1'b1);
    ctrl.idle(12);
    // Legacy latency with the bypass held low
    pllBypassN = 1'b0;
    ctrl.idle(6);
    ctrl.align();
    rd(addrs[6], 2, 1'b1);
    ctrl.idle(12);
    // Reset in mid-burst clears the output, then a read at the first edge
    pllBypassN = 1'b1;
    ctrl.align();
    ctrl.request(1'b1, 1'b0, addrs[7]);
    ctrl.idle(5);
    resetn = 1'b0;
    #1 cmp({readDataOe, readData}, 19'h0);
    ctrl.idle(2);
    cmp({18'h0, negPhase}, 19'h0);
    resetn = 1'b1;
    rd(addrs[7], 5, 1'b1);
    ctrl.idle(12);
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end
endmodule // tb_top
